// >>> logic/acr_regs.sv
// AHB-Lite register block for converter results and converter clock
// What this block does
// - Left mode: bits 9..2 high, 1..0 low
// - Right mode: bits 9..8 high, 7..0 low
// - Truncation: top eight bits low, no interlock
// - High byte read freezes low until read
// - Results dropped while low byte frozen
// - Low byte updates on each completion not dropped by the interlock, high byte too except in truncation
// - Divider code gives 1,2,4,8, or 16
// - Select bit: bus clock set, crystal clear
// - Mode field codes; right justified after reset
// - Done flag stays until result read
// - Status write aborts and restarts conversion
//
// The AHB-Lite interface to the registers is this design's own decision.
module acr_regs (
   input  wire logic                      hclk,
   input  wire logic                      hresetn,
   input  wire logic                      hsel,
   input  wire logic [31:0]               haddr,
   input  wire logic [1:0]                htrans,
   input  wire logic                      hwrite,
   input  wire logic [2:0]                hsize,
   input  wire logic [31:0]               hwdata,
   input  wire logic                      hready,
   output logic                           hreadyout,
   output logic                           hresp,
   output logic [31:0]                    hrdata,
   input  wire logic                      crystal_clock,
   input  wire logic                      conv_done,
   input  wire logic [9:0]                conv_data,
   output logic                           conv_start,
   output logic                           conv_clk_en,
   output logic                           conv_continuous,
   output logic [acr_pkg::CHAN_W-1:0]     conv_channel
);
   import acr_pkg::*;

   acr_req_t              req;
   acr_res_t              res;
   logic                  locked;
   logic                  done_flag;
   logic                  irq_en;
   logic [2:0]            clock_divide_field;
   logic                  input_clock_select;
   acr_mode_t             justification_field;
   logic                  xtal_q;
   logic [3:0]            div_cnt;

   // Division terminal count for a divider code
   function automatic logic [3:0] div_last(input logic [2:0] code);
      logic [3:0] r;
      r = 4'hf;
      if (!code[2]) begin
         r = 4'((5'h1 << code[1:0]) - 5'h1);
      end
      return r;
   endfunction : div_last

   // Result placement for each justification mode
   function automatic acr_res_t place(input acr_mode_t m,
                                      input logic [9:0] d);
      acr_res_t r;
      r = '0;
      case (m)
         ACR_TRUNC8: begin
            r.low = d[9:2];
         end
         ACR_RIGHT: begin
            r.high = {6'h00, d[9:8]};
            r.low  = d[7:0];
         end
         ACR_LEFT: begin
            r.high = d[9:2];
            r.low  = {d[1:0], 6'h00};
         end
         default: begin
            r.high = {~d[9], d[8:2]};
            r.low  = {d[1:0], 6'h00};
         end
      endcase
      return r;
   endfunction : place

   // Address phase decode
   wire        addr_take  = hsel & htrans[1] & hready;
   wire [7:0]  addr_index = haddr[9:2];
   wire        rd_take    = addr_take & ~hwrite;
   wire        rd_high    = rd_take & (addr_index == IDX_RESULT_HIGH);
   wire        rd_low     = rd_take & (addr_index == IDX_RESULT_LOW);
   wire        justified  = (justification_field != ACR_TRUNC8);
   wire        wr_data    = req.valid & req.write;
   wire        wr_status  = wr_data & (req.index == IDX_STATUS_CTRL);
   wire        wr_clock   = wr_data & (req.index == IDX_CLOCK_CFG);

   // Completion accepted unless the interlock holds the bytes
   wire        lock_set   = rd_high & justified;
   wire        res_take   = conv_done & ~locked & ~lock_set;
   wire        lock_clr   = rd_low | ~justified;
   wire        rd_result  = rd_high | rd_low;
   wire        done_set   = res_take & ~irq_en;
   wire        done_view  = done_flag & ~irq_en;
   wire        done_next  = done_set | (done_flag & ~rd_result);
   acr_res_t   placed;
   assign placed = place(justification_field, conv_data);

   wire [7:0]  status_view = {done_view, irq_en, conv_continuous,
                              conv_channel};
   wire [7:0]  clock_view  = {clock_divide_field, input_clock_select,
                              justification_field, 2'h0};
   wire [7:0]  next_read   =
      (addr_index == IDX_STATUS_CTRL) ? status_view :
      (addr_index == IDX_RESULT_HIGH) ? res.high :
      (addr_index == IDX_RESULT_LOW)  ? res.low :
      (addr_index == IDX_CLOCK_CFG)   ? clock_view : 8'h00;

   // Input clock tick: bus clock every cycle, crystal on rising edge
   wire        in_tick  = input_clock_select |
                          (crystal_clock & ~xtal_q);
   wire        div_end  = (div_cnt >= div_last(clock_divide_field));
   wire [3:0]  next_div = div_end ? 4'h0 : div_cnt + 4'h1;

   // Bus slave
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         req       <= '0;
         hrdata    <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         req.valid <= addr_take;
         req.write <= hwrite;
         req.index <= addr_index;
         if (rd_take) begin
            hrdata <= {24'h00_0000, next_read};
         end
      end
   end

   // Software controls; result bytes accept no writes
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_en              <= 1'b0;
         conv_continuous     <= 1'b0;
         conv_channel        <= CHAN_RESET;
         clock_divide_field  <= DIV_RESET;
         input_clock_select  <= ICLK_RESET;
         justification_field <= acr_mode_t'(MODE_RESET);
         conv_start          <= 1'b0;
      end else begin
         conv_start <= wr_status;
         if (wr_status) begin
            irq_en          <= hwdata[IRQEN_BIT];
            conv_continuous <= hwdata[CONT_BIT];
            conv_channel    <= hwdata[CHAN_LSB +: CHAN_W];
         end
         if (wr_clock) begin
            clock_divide_field  <= hwdata[DIV_LSB +: 3];
            input_clock_select  <= hwdata[ICLK_BIT];
            justification_field <= acr_mode_t'(hwdata[MODE_LSB +: 2]);
         end
      end
   end

   // Interlock and completion flag
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         locked    <= 1'b0;
         done_flag <= 1'b0;
      end else begin
         if (lock_set) begin
            locked <= 1'b1;
         end else if (lock_clr) begin
            locked <= 1'b0;
         end
         done_flag <= done_next;
      end
   end

   // Result bytes keep their contents through reset
   always_ff @(posedge hclk) begin
      if (res_take) begin
         res.low <= placed.low;
         if (justified) begin
            res.high <= placed.high;
         end
      end
   end

   // Converter clock divider
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         xtal_q      <= 1'b0;
         div_cnt     <= 4'h0;
         conv_clk_en <= 1'b0;
      end else begin
         xtal_q      <= crystal_clock;
         conv_clk_en <= in_tick & div_end;
         if (in_tick) begin
            div_cnt <= next_div;
         end
      end
   end

   // Checks
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   logic [4:0] gap;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         gap <= 5'h00;
      end else if (conv_clk_en) begin
         gap <= 5'h01;
      end else if (gap != 5'h1f) begin
         gap <= gap + 5'h01;
      end
   end

   sequence s_high_read;
      rd_high && justified;
   endsequence

   sequence s_low_read;
      rd_low;
   endsequence

   a_left_place: assert property (
      res_take && justification_field == ACR_LEFT
      |=> res.high == $past(conv_data[9:2]) &&
          res.low == {$past(conv_data[1:0]), 6'h00})
      else $error("left placement wrong");

   a_right_place: assert property (
      res_take && justification_field == ACR_RIGHT
      |=> res.high == {6'h00, $past(conv_data[9:8])} &&
          res.low == $past(conv_data[7:0]))
      else $error("right placement wrong");

   a_trunc_place: assert property (
      res_take && justification_field == ACR_TRUNC8
      |=> res.low == $past(conv_data[9:2]) && $stable(res.high))
      else $error("truncation placement wrong");

   a_freeze_hold: assert property (
      s_high_read ##1 (!rd_low && justified)[*3]
      |-> $stable(res.low) && locked)
      else $error("low byte not frozen");

   a_lock_release: assert property (
      locked ##0 s_low_read |=> !locked)
      else $error("lock not released by low read");

   a_drop_result: assert property (
      locked && conv_done |=> $stable(res))
      else $error("result taken while locked");

   a_div_sixteen: assert property (
      input_clock_select && clock_divide_field[2] && conv_clk_en
      ##1 (input_clock_select && clock_divide_field[2] && !wr_clock)[*8]
      |-> !conv_clk_en)
      else $error("divide by sixteen too fast");

   a_div_bus_one: assert property (
      input_clock_select && clock_divide_field == 3'h0 && !wr_clock
      ##1 input_clock_select && clock_divide_field == 3'h0
      |=> conv_clk_en && gap == 5'h01)
      else $error("divide by one not every cycle");

   a_flag_stays: assert property (
      done_flag && !rd_result |=> done_flag)
      else $error("done flag lost");

   a_status_start: assert property (
      wr_status |=> conv_start ##1 (conv_start == $past(wr_status)))
      else $error("no start after status write");

   a_signed_top: assert property (
      res_take && justification_field == ACR_LEFTS
      |=> res.high[7] == !$past(conv_data[9]))
      else $error("signed top bit not inverted");

   a_signed_low: assert property (
      res_take && justification_field == ACR_LEFTS
      |=> res.low == {$past(conv_data[1:0]), 6'h00})
      else $error("signed low byte wrong");

   a_trunc_nolock: assert property (
      !justified |=> !locked)
      else $error("lock held in truncation mode");

   a_high_read_drop: assert property (
      lock_set && conv_done |=> $stable(res))
      else $error("result taken on high read");

   a_flag_set: assert property (
      res_take && !irq_en |=> done_flag)
      else $error("done flag not set");

   a_start_cause: assert property (
      conv_start |-> $past(wr_status))
      else $error("start without status write");

endmodule : acr_regs

// >>> logic/acr_pkg.sv
// Constants, register map and carrier types of the converter result block
package acr_pkg;

   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_STATUS_CTRL = 8'h40;
   localparam logic [7:0] IDX_RESULT_HIGH = 8'h41;
   localparam logic [7:0] IDX_RESULT_LOW  = 8'h42;
   localparam logic [7:0] IDX_CLOCK_CFG   = 8'h43;

   // Status and control fields
   localparam int DONE_BIT   = 7;
   localparam int IRQEN_BIT  = 6;
   localparam int CONT_BIT   = 5;
   localparam int CHAN_LSB   = 0;
   localparam int CHAN_W     = 5;

   // Clock configuration fields
   localparam int DIV_LSB    = 5;
   localparam int ICLK_BIT   = 4;
   localparam int MODE_LSB   = 2;

   // Values after reset
   localparam logic [2:0]        DIV_RESET  = 3'h0;
   localparam logic              ICLK_RESET = 1'b0;
   localparam logic [1:0]        MODE_RESET = 2'h1;
   localparam logic [CHAN_W-1:0] CHAN_RESET = 5'h1f;

   // Justification codes
   typedef enum logic [1:0] {
      ACR_TRUNC8 = 2'h0,
      ACR_RIGHT  = 2'h1,
      ACR_LEFT   = 2'h2,
      ACR_LEFTS  = 2'h3
   } acr_mode_t;

   // Captured AHB address phase
   typedef struct packed {
      logic       valid;
      logic       write;
      logic [7:0] index;
   } acr_req_t;

   // Result bytes as a pair
   typedef struct packed {
      logic [7:0] high;
      logic [7:0] low;
   } acr_res_t;

endpackage : acr_pkg

// >>> verification/acr_regs_tb.sv
// Self-checking bench for the converter result and clock registers
module acr_regs_tb;
   import acr_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   logic                hclk;
   logic                hresetn;
   logic                hsel;
   logic [31:0]         haddr;
   logic [1:0]          htrans;
   logic                hwrite;
   logic [2:0]          hsize;
   logic [31:0]         hwdata;
   wire logic           hready;
   logic                hreadyout;
   logic                hresp;
   logic [31:0]         hrdata;
   logic                crystal_clock = 1'b0;
   logic                conv_done;
   logic [9:0]          conv_data;
   logic                conv_start;
   logic                conv_clk_en;
   logic                conv_continuous;
   logic [CHAN_W-1:0]   conv_channel;
   int                  xcnt = 0;
   int                  error_cnt = 0;
   int                  num_checks = 0;

   assign hready = hreadyout;

   acr_regs i_dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .crystal_clock(crystal_clock),
      .conv_done(conv_done), .conv_data(conv_data),
      .conv_start(conv_start), .conv_clk_en(conv_clk_en),
      .conv_continuous(conv_continuous), .conv_channel(conv_channel)
   );

   initial begin
      hclk = 1'b0;
      forever #2.5 hclk = ~hclk;
   end

   // Crystal clock with a period of six bus cycles
   always @(posedge hclk) begin
      if (xcnt == 2) begin
         xcnt <= 0;
         crystal_clock <= ~crystal_clock;
      end else begin
         xcnt <= xcnt + 1;
      end
   end

   task automatic check(input string name, input logic [31:0] seen,
                        input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic test_done;
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : test_done

   // One single AHB transfer, address phase then data phase
   task automatic bus(input logic w, input logic [7:0] idx,
                      input logic [31:0] wd, output logic [31:0] rd);
      int n;
      bit late;
      hsel <= 1'b1;
      haddr <= {22'h0, idx, 2'h0};
      htrans <= 2'h2;
      hwrite <= w;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      late = (n >= 50);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wd;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      rd = hrdata;
      check("hresp", {31'h0, hresp}, 32'h0);
      if (late || n >= 50) begin
         error_cnt++;
         test_done();
      end
   endtask : bus

   task automatic conv(input logic [9:0] d);
      conv_done <= 1'b1;
      conv_data <= d;
      @(posedge hclk);
      conv_done <= 1'b0;
      @(posedge hclk);
   endtask : conv

   // Cycles between two converter clock pulses
   task automatic gap_of(output int g);
      int n;
      n = 0;
      while (conv_clk_en !== 1'b1 && n < 200) begin
         @(posedge hclk);
         n++;
      end
      g = 0;
      do begin
         @(posedge hclk);
         g++;
      end while (conv_clk_en !== 1'b1 && g < 200);
      if (n >= 200 || g >= 200) begin
         error_cnt++;
         test_done();
      end
   endtask : gap_of

   function automatic logic [15:0] place(input int m, input logic [9:0] d,
                                         input logic [7:0] keep);
      case (m)
         0: place = {keep, d[9:2]};
         1: place = {6'h0, d};
         2: place = {d[9:2], d[1:0], 6'h0};
         default: place = {~d[9], d[8:2], d[1:0], 6'h0};
      endcase
   endfunction : place

   initial begin
      logic [31:0] rd;
      logic [15:0] exp;
      int          g;
      int          ms[4];
      ms = '{1, 2, 3, 0};
      exp = 16'h0;
      hresetn = 1'b0;
      {hsel, hwrite, conv_done} = 3'h0;
      haddr = 32'h0;
      htrans = 2'h0;
      hsize = 3'h2;
      hwdata = 32'h0;
      conv_data = 10'h0;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      bus(1'b0, IDX_CLOCK_CFG, 32'h0, rd);
      check("clock_cfg_reset", rd, 32'h4);
      bus(1'b0, 8'h50, 32'h0, rd);
      check("unmapped", rd, 32'h0);
      $display("test reset done");
      for (int i = 0; i < 4; i++) begin
         bus(1'b1, IDX_CLOCK_CFG, {24'h0, 4'h1, ms[i][1:0], 2'h0}, rd);
         exp = place(ms[i], 10'h2d5, exp[15:8]);
         conv(10'h2d5);
         bus(1'b0, IDX_RESULT_HIGH, 32'h0, rd);
         check("result_high", rd, {24'h0, exp[15:8]});
         bus(1'b0, IDX_RESULT_LOW, 32'h0, rd);
         check("result_low", rd, {24'h0, exp[7:0]});
      end
      $display("test modes done");
      // Truncation: a new result passes although high was read
      conv(10'h0f3);
      bus(1'b0, IDX_RESULT_HIGH, 32'h0, rd);
      conv(10'h30c);
      bus(1'b0, IDX_RESULT_LOW, 32'h0, rd);
      check("trunc_low", rd, 32'hc3);
      // Right justified interlock
      bus(1'b1, IDX_CLOCK_CFG, 32'h14, rd);
      conv(10'h1a5);
      bus(1'b0, IDX_RESULT_HIGH, 32'h0, rd);
      check("lock_high", rd, 32'h1);
      conv(10'h25a);
      bus(1'b0, IDX_RESULT_LOW, 32'h0, rd);
      check("lock_low", rd, 32'ha5);
      bus(1'b0, IDX_RESULT_HIGH, 32'h0, rd);
      check("lock_drop", rd, 32'h1);
      bus(1'b1, IDX_RESULT_HIGH, 32'hff, rd);
      bus(1'b0, IDX_RESULT_LOW, 32'h0, rd);
      conv(10'h25a);
      bus(1'b0, IDX_RESULT_HIGH, 32'h0, rd);
      check("relock_high", rd, 32'h2);
      bus(1'b0, IDX_RESULT_LOW, 32'h0, rd);
      check("relock_low", rd, 32'h5a);
      $display("test interlock done");
      conv(10'h301);
      bus(1'b0, IDX_STATUS_CTRL, 32'h0, rd);
      check("done_set", {31'h0, rd[DONE_BIT]}, 32'h1);
      bus(1'b0, IDX_RESULT_LOW, 32'h0, rd);
      bus(1'b0, IDX_STATUS_CTRL, 32'h0, rd);
      check("done_clear", {31'h0, rd[DONE_BIT]}, 32'h0);
      bus(1'b1, IDX_STATUS_CTRL, 32'h23, rd);
      #1;
      check("start_pulse", {31'h0, conv_start}, 32'h1);
      check("continuous", {31'h0, conv_continuous}, 32'h1);
      check("channel", {27'h0, conv_channel}, 32'h3);
      @(posedge hclk);
      #1;
      check("start_end", {31'h0, conv_start}, 32'h0);
      @(posedge hclk);
      $display("test status done");
      // Interrupt mode keeps the done flag clear
      bus(1'b1, IDX_STATUS_CTRL, 32'h40, rd);
      conv(10'h3aa);
      bus(1'b0, IDX_STATUS_CTRL, 32'h0, rd);
      check("irq_status", rd, 32'h40);
      // Reset in mid run leaves the result bytes alone
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      check("channel_reset", {27'h0, conv_channel}, 32'h1f);
      check("continuous_reset", {31'h0, conv_continuous}, 32'h0);
      bus(1'b0, IDX_RESULT_HIGH, 32'h0, rd);
      check("keep_high", rd, 32'h3);
      bus(1'b0, IDX_RESULT_LOW, 32'h0, rd);
      check("keep_low", rd, 32'haa);
      bus(1'b0, IDX_STATUS_CTRL, 32'h0, rd);
      check("status_reset", rd, 32'h1f);
      bus(1'b0, IDX_CLOCK_CFG, 32'h0, rd);
      check("clock_cfg_again", rd, 32'h4);
      $display("test reset again done");
      for (int i = 0; i < 6; i++) begin
         logic [2:0] code;
         code = (i == 5) ? 3'h7 : 3'(i);
         bus(1'b1, IDX_CLOCK_CFG, {24'h0, code, 5'h14}, rd);
         gap_of(g);
         gap_of(g);
         check("bus_div", 32'(g), 32'(1 << ((i > 3) ? 4 : i)));
      end
      for (int i = 0; i < 2; i++) begin
         bus(1'b1, IDX_CLOCK_CFG, {24'h0, 3'(i), 5'h04}, rd);
         gap_of(g);
         gap_of(g);
         check("xtal_div", 32'(g), 32'(6 << i));
      end
      $display("test divider done");
      test_done();
   end

   initial begin
      #200000;
      error_cnt++;
      test_done();
   end

endmodule : acr_regs_tb
